// [design/smp_route_pkg.sv]
package smp_route_pkg;
  // frame codes
  localparam logic [7:0] REQ_FRAME_TYPE = 8'h40;
  localparam logic [7:0] RSP_FRAME_TYPE = 8'h41;
  localparam logic [7:0] FUNC_ROUTE_REPORT = 8'h13;
  // function results
  localparam logic [7:0] RES_ACCEPTED = 8'h00;
  localparam logic [7:0] RES_UNKNOWN_FUNC = 8'h01;
  localparam logic [7:0] RES_NO_PHY = 8'h10;
  localparam logic [7:0] RES_BAD_INDEX = 8'h22;
  // frame layout, byte positions
  localparam int REQ_LEN = 16;
  localparam int RSP_LEN = 44;
  localparam int REQ_CRC_POS = 12;
  localparam int RSP_CRC_POS = 40;
  localparam int POS_TYPE = 0;
  localparam int POS_FUNC = 1;
  localparam int POS_RESULT = 2;
  localparam int POS_IDX_HI = 6;
  localparam int POS_IDX_LO = 7;
  localparam int POS_PHY = 9;
  localparam int POS_DIS = 12;
  localparam int DIS_BIT = 7;
  localparam int POS_ADDR = 16;
  localparam int POS_ADDR_END = 23;
  // frame check sequence
  localparam logic [31:0] CRC_POLY = 32'h04c11db7;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;
  // controller registers, byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_QUERY = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_RESULT = 8'h0c;
  localparam logic [7:0] REG_ADDR_HI = 8'h10;
  localparam logic [7:0] REG_ADDR_LO = 8'h14;
  localparam int CTRL_START = 0;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_ERR = 2;
  localparam int ST_DISABLED = 8;
  localparam logic [31:0] QUERY_RST = 32'h0000_0000;

  // msb-first crc, one byte per call
  function automatic logic [31:0] crc_byte(input logic [31:0] crc,
                                           input logic [7:0] data);
    logic [31:0] c;
    c = crc;
    for (int i = 7; i >= 0; i--) begin
      c = (c[31] ^ data[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction
endpackage

// [design/smp_link_if.sv]
interface smp_link_if;
  logic req_valid;
  logic [7:0] req_data;
  logic req_last;
  logic rsp_valid;
  logic [7:0] rsp_data;
  logic rsp_last;

  modport initiator (
    output req_valid, req_data, req_last,
    input rsp_valid, rsp_data, rsp_last
  );
  modport target (
    input req_valid, req_data, req_last,
    output rsp_valid, rsp_data, rsp_last
  );
endinterface

// [design/smp_route_target.sv]
// Behaviour
// [RL1] answer queries when route indexes advertised nonzero
// [RL2] request byte 0 carries 40h
// [RL3] request and response byte 1 carry 13h
// [RL4] response byte 0 carries 41h
// [RL5] request route index bytes 6-7, msb first
// [RL6] request byte 9 phy selects entry
// [RL7] response echoes route index bytes 6-7
// [RL8] response echoes phy in byte 9
// [RL9] result code in byte 2, 3-5 reserved
// [RL10] byte 12 bit 7 is entry disable
// [RL11] routed address bytes 16-23, 24-39 reserved
// [RL12] request ends with crc bytes 12-15
// [RL13] response ends with crc bytes 40-43
// [RL14] out-of-range index or phy gives error result
// [RL15] bad request crc dropped before table lookup
module smp_route_target #(
  parameter int NUM_PHY = 8,
  parameter int NUM_INDEX = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // link
  smp_link_if.target link,
  // route table load from configuration logic
  input wire logic tbl_we_i,
  input wire logic [7:0] tbl_phy_i,
  input wire logic [15:0] tbl_idx_i,
  input wire logic tbl_disable_i,
  input wire logic [63:0] tbl_addr_i,
  // advertised route index count
  input wire logic [15:0] route_indexes_i,
  // status
  output logic bad_frame_o
);
  import smp_route_pkg::*;

  localparam int ENTRIES = NUM_PHY * NUM_INDEX;
  localparam int TW = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;

  typedef enum logic [1:0] {S_RX, S_LOOK, S_TX} state_t;

  state_t state_q, state_d;
  logic [5:0] cnt_q, cnt_d;
  logic [127:0] frame_q, frame_d;
  logic [31:0] crc_q, crc_d;
  logic [7:0] result_q, result_d;
  logic ent_dis_q, ent_dis_d;
  logic [63:0] ent_addr_q, ent_addr_d;
  logic [7:0] rsp_data_q, rsp_data_d;
  logic rsp_valid_q, rsp_valid_d;
  logic rsp_last_q, rsp_last_d;
  logic bad_q, bad_d;

  logic [64:0] tbl_q [ENTRIES];

  logic [7:0] req_type, req_func, req_phy;
  logic [15:0] req_idx;
  logic [TW-1:0] look_addr;
  logic [7:0] tx_byte;

  // decoded fields of the held request, byte k at [127-8k -: 8]
  assign req_type = frame_q[127 - 8*POS_TYPE -: 8];
  assign req_func = frame_q[127 - 8*POS_FUNC -: 8];
  assign req_idx = {frame_q[127 - 8*POS_IDX_HI -: 8],
                    frame_q[127 - 8*POS_IDX_LO -: 8]}; // RL5
  assign req_phy = frame_q[127 - 8*POS_PHY -: 8];
  assign look_addr = TW'(32'(req_phy) * NUM_INDEX + 32'(req_idx)); // RL6

  // table loads use the same phy-major layout as the lookup
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < ENTRIES; i++) begin
        tbl_q[i] <= '0;
      end
    end else if (tbl_we_i && 32'(tbl_phy_i) < NUM_PHY &&
                 32'(tbl_idx_i) < NUM_INDEX) begin
      tbl_q[TW'(32'(tbl_phy_i) * NUM_INDEX + 32'(tbl_idx_i))] <=
        {tbl_disable_i, tbl_addr_i};
    end
  end

  // response byte for the current position
  always_comb begin
    tx_byte = 8'h00; // RL9 RL11
    if (cnt_q == 6'(POS_TYPE)) begin
      tx_byte = RSP_FRAME_TYPE; // RL4
    end else if (cnt_q == 6'(POS_FUNC)) begin
      tx_byte = FUNC_ROUTE_REPORT; // RL3
    end else if (cnt_q == 6'(POS_RESULT)) begin
      tx_byte = result_q; // RL9
    end else if (cnt_q == 6'(POS_IDX_HI)) begin
      tx_byte = req_idx[15:8]; // RL7
    end else if (cnt_q == 6'(POS_IDX_LO)) begin
      tx_byte = req_idx[7:0]; // RL7
    end else if (cnt_q == 6'(POS_PHY)) begin
      tx_byte = req_phy; // RL8
    end else if (cnt_q == 6'(POS_DIS)) begin
      tx_byte = 8'(ent_dis_q) << DIS_BIT; // RL10
    end else if (cnt_q >= 6'(POS_ADDR) && cnt_q <= 6'(POS_ADDR_END)) begin
      tx_byte = ent_addr_q[8*(POS_ADDR_END - 32'(cnt_q)) +: 8]; // RL11
    end else if (cnt_q >= 6'(RSP_CRC_POS)) begin
      tx_byte = crc_q[8*(RSP_LEN - 1 - 32'(cnt_q)) +: 8]; // RL13
    end
  end

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    frame_d = frame_q;
    crc_d = crc_q;
    result_d = result_q;
    ent_dis_d = ent_dis_q;
    ent_addr_d = ent_addr_q;
    rsp_data_d = 8'h00;
    rsp_valid_d = 1'b0;
    rsp_last_d = 1'b0;
    bad_d = 1'b0;
    case (state_q)
      S_RX: begin
        if (link.req_valid) begin
          frame_d = {frame_q[119:0], link.req_data};
          if (cnt_q < 6'(REQ_CRC_POS)) begin
            crc_d = crc_byte(crc_q, link.req_data);
          end
          // saturate so an overlong frame can never look complete
          if (cnt_q != 6'h3f) begin
            cnt_d = cnt_q + 6'h01;
          end
          if (link.req_last) begin
            cnt_d = 6'h00;
            crc_d = CRC_INIT;
            // trailing crc checked before any table access
            // byte 0 sits one byte below the top until the final shift
            if (cnt_q == 6'(REQ_LEN - 1) &&
                frame_q[8*(REQ_LEN - 1) - 1 -: 8] == REQ_FRAME_TYPE &&
                crc_q == {frame_q[23:0], link.req_data}) begin // RL2 RL12
              state_d = S_LOOK;
            end else begin
              bad_d = 1'b1; // RL15
            end
          end
        end
      end
      S_LOOK: begin
        ent_dis_d = 1'b0;
        ent_addr_d = '0;
        if (req_func != FUNC_ROUTE_REPORT ||
            route_indexes_i == 16'h0000) begin
          result_d = RES_UNKNOWN_FUNC; // RL1 RL3
        end else if (32'(req_phy) >= NUM_PHY) begin
          result_d = RES_NO_PHY; // RL14
        end else if (32'(req_idx) >= NUM_INDEX ||
                     req_idx >= route_indexes_i) begin
          result_d = RES_BAD_INDEX; // RL14
        end else begin
          result_d = RES_ACCEPTED;
          ent_dis_d = tbl_q[look_addr][64]; // RL6 RL10
          ent_addr_d = tbl_q[look_addr][63:0]; // RL11
        end
        state_d = S_TX;
      end
      S_TX: begin
        rsp_valid_d = 1'b1;
        rsp_data_d = tx_byte;
        if (cnt_q < 6'(RSP_CRC_POS)) begin
          crc_d = crc_byte(crc_q, tx_byte); // RL13
        end
        cnt_d = cnt_q + 6'h01;
        if (cnt_q == 6'(RSP_LEN - 1)) begin
          rsp_last_d = 1'b1;
          cnt_d = 6'h00;
          crc_d = CRC_INIT;
          state_d = S_RX;
        end
      end
      default: begin
        state_d = S_RX;
        cnt_d = 6'h00;
        crc_d = CRC_INIT;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= S_RX;
      cnt_q <= 6'h00;
      frame_q <= '0;
      crc_q <= CRC_INIT;
      result_q <= RES_ACCEPTED;
      ent_dis_q <= 1'b0;
      ent_addr_q <= '0;
      rsp_data_q <= 8'h00;
      rsp_valid_q <= 1'b0;
      rsp_last_q <= 1'b0;
      bad_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      frame_q <= frame_d;
      crc_q <= crc_d;
      result_q <= result_d;
      ent_dis_q <= ent_dis_d;
      ent_addr_q <= ent_addr_d;
      rsp_data_q <= rsp_data_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_last_q <= rsp_last_d;
      bad_q <= bad_d;
    end
  end

  assign link.rsp_valid = rsp_valid_q;
  assign link.rsp_data = rsp_data_q;
  assign link.rsp_last = rsp_last_q;
  assign bad_frame_o = bad_q;
endmodule

// [design/smp_route_initiator.sv]
module smp_route_initiator (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // link
  smp_link_if.initiator link
);
  import smp_route_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_SEND, H_RECV} hstate_t;

  hstate_t state_q, state_d;
  logic [5:0] cnt_q, cnt_d;
  logic [31:0] crc_q, crc_d;
  logic [23:0] tail_q, tail_d;
  logic hdr_ok_q, hdr_ok_d;
  logic [7:0] req_data_q, req_data_d;
  logic req_valid_q, req_valid_d;
  logic req_last_q, req_last_d;
  logic [31:0] query_q, query_d;
  logic done_q, done_d;
  logic err_q, err_d;
  logic [7:0] res_q, res_d;
  logic [7:0] rphy_q, rphy_d;
  logic [15:0] ridx_q, ridx_d;
  logic rdis_q, rdis_d;
  logic [63:0] raddr_q, raddr_d;
  logic [31:0] dat_q, dat_d;
  logic ack_q, ack_d;
  logic [7:0] tx_byte;
  logic wr, start, rx_good;

  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q;
  assign start = wr && wb_adr_i == REG_CTRL && wb_sel_i[0] &&
                 wb_dat_i[CTRL_START];

  // request byte; query holds index [15:0], phy [23:16]
  always_comb begin
    tx_byte = 8'h00;
    if (cnt_q == 6'(POS_TYPE)) begin
      tx_byte = REQ_FRAME_TYPE; // RL2
    end else if (cnt_q == 6'(POS_FUNC)) begin
      tx_byte = FUNC_ROUTE_REPORT; // RL3
    end else if (cnt_q == 6'(POS_IDX_HI)) begin
      tx_byte = query_q[15:8]; // RL5
    end else if (cnt_q == 6'(POS_IDX_LO)) begin
      tx_byte = query_q[7:0]; // RL5
    end else if (cnt_q == 6'(POS_PHY)) begin
      tx_byte = query_q[23:16]; // RL6
    end else if (cnt_q >= 6'(REQ_CRC_POS)) begin
      tx_byte = crc_q[8*(REQ_LEN - 1 - 32'(cnt_q)) +: 8]; // RL12
    end
  end

  assign rx_good = hdr_ok_q && cnt_q == 6'(RSP_LEN - 1) &&
                   crc_q == {tail_q, link.rsp_data};

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    crc_d = crc_q;
    tail_d = tail_q;
    hdr_ok_d = hdr_ok_q;
    req_data_d = 8'h00;
    req_valid_d = 1'b0;
    req_last_d = 1'b0;
    query_d = query_q;
    done_d = done_q;
    err_d = err_q;
    res_d = res_q;
    rphy_d = rphy_q;
    ridx_d = ridx_q;
    rdis_d = rdis_q;
    raddr_d = raddr_q;
    // software clears first so a same-cycle hardware set wins
    if (wr && wb_adr_i == REG_STATUS && wb_sel_i[0]) begin
      if (wb_dat_i[ST_DONE]) begin
        done_d = 1'b0;
      end
      if (wb_dat_i[ST_ERR]) begin
        err_d = 1'b0;
      end
    end
    if (wr && wb_adr_i == REG_QUERY && state_q == H_IDLE) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b]) begin
          query_d[8*b +: 8] = wb_dat_i[8*b +: 8];
        end
      end
    end
    case (state_q)
      H_IDLE: begin
        if (start) begin
          state_d = H_SEND;
          cnt_d = 6'h00;
          crc_d = CRC_INIT;
        end
      end
      H_SEND: begin
        req_valid_d = 1'b1;
        req_data_d = tx_byte;
        if (cnt_q < 6'(REQ_CRC_POS)) begin
          crc_d = crc_byte(crc_q, tx_byte); // RL12
        end
        cnt_d = cnt_q + 6'h01;
        if (cnt_q == 6'(REQ_LEN - 1)) begin
          req_last_d = 1'b1;
          state_d = H_RECV;
          cnt_d = 6'h00;
          crc_d = CRC_INIT;
          hdr_ok_d = 1'b1;
        end
      end
      H_RECV: begin
        if (link.rsp_valid) begin
          tail_d = {tail_q[15:0], link.rsp_data};
          if (cnt_q < 6'(RSP_CRC_POS)) begin
            crc_d = crc_byte(crc_q, link.rsp_data); // RL13
          end
          if ((cnt_q == 6'(POS_TYPE) && link.rsp_data != RSP_FRAME_TYPE) ||
              (cnt_q == 6'(POS_FUNC) &&
               link.rsp_data != FUNC_ROUTE_REPORT)) begin
            hdr_ok_d = 1'b0; // RL3 RL4
          end
          if (cnt_q != 6'h3f) begin
            cnt_d = cnt_q + 6'h01;
          end
          if (link.rsp_last) begin
            state_d = H_IDLE;
            cnt_d = 6'h00;
            if (rx_good) begin
              done_d = 1'b1;
            end else begin
              err_d = 1'b1;
            end
          end
        end
      end
      default: begin
        state_d = H_IDLE;
      end
    endcase
  end

  // response fields, kept only from a frame that checks out
  logic [7:0] fres_q, fres_d;
  logic [7:0] fphy_q, fphy_d;
  logic [15:0] fidx_q, fidx_d;
  logic fdis_q, fdis_d;
  logic [63:0] faddr_q, faddr_d;

  always_comb begin
    fres_d = fres_q;
    fphy_d = fphy_q;
    fidx_d = fidx_q;
    fdis_d = fdis_q;
    faddr_d = faddr_q;
    if (state_q == H_RECV && link.rsp_valid) begin
      if (cnt_q == 6'(POS_RESULT)) begin
        fres_d = link.rsp_data; // RL9
      end
      if (cnt_q == 6'(POS_IDX_HI)) begin
        fidx_d[15:8] = link.rsp_data; // RL7
      end
      if (cnt_q == 6'(POS_IDX_LO)) begin
        fidx_d[7:0] = link.rsp_data; // RL7
      end
      if (cnt_q == 6'(POS_PHY)) begin
        fphy_d = link.rsp_data; // RL8
      end
      if (cnt_q == 6'(POS_DIS)) begin
        fdis_d = link.rsp_data[DIS_BIT]; // RL10
      end
      if (cnt_q >= 6'(POS_ADDR) && cnt_q <= 6'(POS_ADDR_END)) begin
        faddr_d = {faddr_q[55:0], link.rsp_data}; // RL11
      end
    end
  end

  always_comb begin
    ack_d = wb_cyc_i && wb_stb_i && !ack_q;
    case (wb_adr_i)
      REG_QUERY: dat_d = query_q;
      REG_STATUS: dat_d = 32'(rdis_q) << ST_DISABLED |
                          32'(err_q) << ST_ERR | 32'(done_q) << ST_DONE |
                          32'(state_q != H_IDLE) << ST_BUSY;
      REG_RESULT: dat_d = {ridx_q, rphy_q, res_q};
      REG_ADDR_HI: dat_d = raddr_q[63:32];
      REG_ADDR_LO: dat_d = raddr_q[31:0];
      default: dat_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= H_IDLE;
      cnt_q <= 6'h00;
      crc_q <= CRC_INIT;
      tail_q <= '0;
      hdr_ok_q <= 1'b0;
      req_data_q <= 8'h00;
      req_valid_q <= 1'b0;
      req_last_q <= 1'b0;
      query_q <= QUERY_RST;
      done_q <= 1'b0;
      err_q <= 1'b0;
      res_q <= 8'h00;
      rphy_q <= 8'h00;
      ridx_q <= 16'h0000;
      rdis_q <= 1'b0;
      raddr_q <= '0;
      fres_q <= 8'h00;
      fphy_q <= 8'h00;
      fidx_q <= 16'h0000;
      fdis_q <= 1'b0;
      faddr_q <= '0;
      dat_q <= 32'h0000_0000;
      ack_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      crc_q <= crc_d;
      tail_q <= tail_d;
      hdr_ok_q <= hdr_ok_d;
      req_data_q <= req_data_d;
      req_valid_q <= req_valid_d;
      req_last_q <= req_last_d;
      query_q <= query_d;
      done_q <= done_d;
      err_q <= err_d;
      fres_q <= fres_d;
      fphy_q <= fphy_d;
      fidx_q <= fidx_d;
      fdis_q <= fdis_d;
      faddr_q <= faddr_d;
      if (state_q == H_RECV && link.rsp_valid && link.rsp_last &&
          rx_good) begin
        res_q <= fres_q;
        rphy_q <= fphy_q;
        ridx_q <= fidx_q;
        rdis_q <= fdis_q;
        raddr_q <= faddr_q;
      end
      dat_q <= dat_d;
      ack_q <= ack_d;
    end
  end

  assign link.req_valid = req_valid_q;
  assign link.req_data = req_data_q;
  assign link.req_last = req_last_q;
  assign wb_dat_o = dat_q;
  assign wb_ack_o = ack_q;
endmodule

// [tb/smp_route_checker.sv]
module smp_route_checker (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // request side
  input wire logic req_valid,
  input wire logic [7:0] req_data,
  input wire logic req_last,
  // response side
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_last
);
  import smp_route_pkg::*;
  logic [4:0] qc_q, qc_d;
  logic [5:0] rc_q, rc_d;
  logic [23:0] key_q, key_d;
  logic rsv;
  always_comb begin
    qc_d = qc_q;
    rc_d = rc_q;
    key_d = key_q;
    if (req_valid) begin
      qc_d = req_last ? 5'h00 : qc_q + 5'h01;
      if (qc_q == 5'h06) key_d[23:16] = req_data;
      if (qc_q == 5'h07) key_d[15:8] = req_data;
      if (qc_q == 5'h09) key_d[7:0] = req_data;
    end
    if (rsp_valid) rc_d = rsp_last ? 6'h00 : rc_q + 6'h01;
  end
  always_ff @(posedge clk_i) begin
    qc_q <= rst_i ? 5'h00 : qc_d;
    rc_q <= rst_i ? 6'h00 : rc_d;
    key_q <= key_d;
  end
  assign rsv = rc_q inside {[6'h03:6'h05], 6'h08, 6'h0a, 6'h0b,
                            [6'h0d:6'h0f], [6'h18:6'h27]};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence req_end;
    req_valid && req_last;
  endsequence
  sequence rsp_begin;
    !rsp_valid ##1 rsp_valid;
  endsequence
  a_req_type_code: assert property (
    req_valid && qc_q == 5'h00 |-> req_data == 8'h40)
    else $error("request type byte wrong");
  a_req_func_code: assert property (
    req_valid && qc_q == 5'h01 |-> req_data == 8'h13)
    else $error("request function byte wrong");
  a_req_frame_len: assert property (
    req_end |-> qc_q == 5'h0f)
    else $error("request length wrong");
  a_rsp_latency: assert property (
    req_end |=> ##1 rsp_begin)
    else $error("response did not start in time");
  a_rsp_type_code: assert property (
    rsp_valid && rc_q == 6'h00 |-> rsp_data == 8'h41)
    else $error("response type byte wrong");
  a_rsp_func_code: assert property (
    rsp_valid && rc_q == 6'h01 |-> rsp_data == 8'h13)
    else $error("response function byte wrong");
  a_rsp_index_echo: assert property (
    rsp_valid && rc_q inside {6'h06, 6'h07} |->
    rsp_data == (rc_q[0] ? key_q[15:8] : key_q[23:16]))
    else $error("response index wrong");
  a_rsp_phy_echo: assert property (
    rsp_valid && rc_q == 6'h09 |-> rsp_data == key_q[7:0])
    else $error("response phy wrong");
  a_rsp_reserved_zero: assert property (
    rsp_valid && rsv |-> rsp_data == 8'h00)
    else $error("reserved response byte not zero");
  a_rsp_dis_only: assert property (
    rsp_valid && rc_q == 6'h0c |-> rsp_data[6:0] == 7'h00)
    else $error("byte 12 low bits not zero");
  a_rsp_burst_whole: assert property (
    rsp_valid && !rsp_last |=> rsp_valid)
    else $error("response burst broken");
  a_rsp_frame_len: assert property (
    rsp_valid && rsp_last |-> rc_q == 6'h2b)
    else $error("response length wrong");
endmodule

// [tb/test_smp_route_entry_report.sv]
module test_smp_route_entry_report;
  timeunit 1ns;
  timeprecision 1ps;
  import smp_route_pkg::*;
  logic clk_i, rst_i, cyc, stb, we, ack, tbl_we, tbl_dis, bad_a, bad_b;
  logic [7:0] adr, tbl_phy;
  logic [3:0] sel;
  logic [15:0] tbl_idx, nidx;
  logic [31:0] wdat, rdat;
  logic [63:0] tbl_addr;
  int miscompares = 0;
  int checks = 0;
  int drops_a = 0;
  smp_link_if link_a ();
  smp_link_if link_b ();
  smp_route_target u_smp_route_target (.clk_i(clk_i), .rst_i(rst_i),
    .link(link_a), .tbl_we_i(tbl_we), .tbl_phy_i(tbl_phy),
    .tbl_idx_i(tbl_idx), .tbl_disable_i(tbl_dis), .tbl_addr_i(tbl_addr),
    .route_indexes_i(nidx), .bad_frame_o(bad_a));
  // second target faces the bench, for one good frame and for frames the initiator never makes
  smp_route_target u_smp_route_target_b (.clk_i(clk_i), .rst_i(rst_i),
    .link(link_b), .tbl_we_i(tbl_we), .tbl_phy_i(tbl_phy),
    .tbl_idx_i(tbl_idx), .tbl_disable_i(tbl_dis), .tbl_addr_i(tbl_addr),
    .route_indexes_i(nidx), .bad_frame_o(bad_b));
  smp_route_initiator u_smp_route_initiator (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .link(link_a));
  smp_route_checker u_smp_route_checker (.clk_i(clk_i), .rst_i(rst_i),
    .req_valid(link_a.req_valid), .req_data(link_a.req_data),
    .req_last(link_a.req_last), .rsp_valid(link_a.rsp_valid),
    .rsp_data(link_a.rsp_data), .rsp_last(link_a.rsp_last));
  // every initiator frame is well formed, so the first target never drops
  always @(negedge clk_i) begin
    if (bad_a === 1'b1) drops_a++;
  end

  task automatic chk(input string what, input logic [31:0] exp, got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic load(input logic [7:0] p, input logic [15:0] i,
                      input logic d, input logic [63:0] a);
    @(posedge clk_i);
    tbl_we <= 1'b1;
    tbl_phy <= p;
    tbl_idx <= i;
    tbl_dis <= d;
    tbl_addr <= a;
    @(posedge clk_i);
    tbl_we <= 1'b0;
  endtask
  task automatic query(input logic [7:0] p, input logic [15:0] i,
    input logic [7:0] res, input logic d, input logic [63:0] a);
    logic [31:0] q;
    int n;
    wb(1'b1, REG_QUERY, {8'h00, p, i}, q);
    wb(1'b1, REG_CTRL, 32'h0000_0001, q);
    n = 0;
    do begin
      wb(1'b0, REG_STATUS, 32'h0, q);
      n++;
    end while (q[ST_DONE] !== 1'b1 && n < 60);
    chk("done", 1, q[ST_DONE]);
    chk("error", 0, q[ST_ERR]);
    chk("disabled", d, q[ST_DISABLED]);
    wb(1'b0, REG_RESULT, 32'h0, q);
    chk("result", {i, p, res}, q);
    wb(1'b0, REG_ADDR_HI, 32'h0, q);
    chk("addr_hi", a[63:32], q);
    wb(1'b0, REG_ADDR_LO, 32'h0, q);
    chk("addr_lo", a[31:0], q);
    wb(1'b1, REG_STATUS, 32'h0000_0006, q);
  endtask
  function automatic logic [31:0] crc_of(input logic [7:0] f[16]);
    logic [31:0] c;
    c = CRC_INIT;
    for (int k = 0; k < 12; k++)
      for (int b = 7; b >= 0; b--)
        c = (c[31] ^ f[k][b]) ? (c << 1) ^ CRC_POLY : c << 1;
    return c;
  endfunction
  task automatic frame_b(input logic [7:0] typ, input logic [31:0] flip,
                         input logic ok);
    logic [7:0] f[16];
    int got, bad;
    f = '{default: 8'h00};
    f[0] = typ;
    f[1] = FUNC_ROUTE_REPORT;
    f[7] = 8'h05;
    f[9] = 8'h03;
    {f[12], f[13], f[14], f[15]} = crc_of(f) ^ flip;
    got = 0;
    bad = 0;
    for (int k = 0; k < 16; k++) begin
      @(posedge clk_i);
      link_b.req_valid <= 1'b1;
      link_b.req_data <= f[k];
      link_b.req_last <= (k == 15);
    end
    @(posedge clk_i);
    link_b.req_valid <= 1'b0;
    link_b.req_last <= 1'b0;
    // released line must not look like a held byte
    link_b.req_data <= ~f[15];
    repeat (60) begin
      @(negedge clk_i);
      if (got == 0 && link_b.rsp_valid === 1'b1)
        chk("b type", RSP_FRAME_TYPE, link_b.rsp_data);
      if (link_b.rsp_valid === 1'b1) got++;
      if (bad_b === 1'b1) bad++;
    end
    chk("b bytes", ok ? 44 : 0, got);
    chk("b dropped", ok ? 0 : 1, bad);
  endtask

  task automatic t_reset();
    logic [31:0] q;
    wb(1'b0, REG_QUERY, 32'h0, q);
    chk("query reset", QUERY_RST, q);
    wb(1'b0, REG_STATUS, 32'h0, q);
    chk("status reset", 32'h0, q);
    wb(1'b1, 8'h20, 32'hffff_ffff, q);
    wb(1'b0, 8'h20, 32'h0, q);
    chk("unmapped", 32'h0, q);
    $display("test reset done");
  endtask
  task automatic t_lookup();
    load(8'h00, 16'h0000, 1'b0, 64'h5000_0000_0000_00a1);
    load(8'h07, 16'h000f, 1'b1, 64'h5000_0c00_1234_00b2);
    load(8'h03, 16'h0005, 1'b0, 64'h5ace_0000_8765_43c3);
    query(8'h00, 16'h0000, RES_ACCEPTED, 1'b0, 64'h5000_0000_0000_00a1);
    query(8'h07, 16'h000f, RES_ACCEPTED, 1'b1, 64'h5000_0c00_1234_00b2);
    query(8'h03, 16'h0005, RES_ACCEPTED, 1'b0, 64'h5ace_0000_8765_43c3);
    query(8'h02, 16'h0005, RES_ACCEPTED, 1'b0, 64'h0);
    $display("test lookup done");
  endtask
  task automatic t_range();
    query(8'h08, 16'h0005, RES_NO_PHY, 1'b0, 64'h0);
    query(8'h03, 16'h0010, RES_BAD_INDEX, 1'b0, 64'h0);
    @(posedge clk_i);
    nidx <= 16'h0005;
    query(8'h03, 16'h0005, RES_BAD_INDEX, 1'b0, 64'h0);
    @(posedge clk_i);
    nidx <= 16'h0000;
    query(8'h00, 16'h0000, RES_UNKNOWN_FUNC, 1'b0, 64'h0);
    @(posedge clk_i);
    nidx <= 16'h0010;
    $display("test range done");
  endtask
  task automatic t_frames();
    frame_b(REQ_FRAME_TYPE, 32'h0, 1'b1);
    frame_b(REQ_FRAME_TYPE, 32'h0000_0100, 1'b0);
    frame_b(8'h42, 32'h0, 1'b0);
    chk("a dropped", 0, drops_a);
    $display("test frames done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  initial begin
    rst_i = 1'b1;
    {cyc, stb, we, tbl_we, tbl_dis} = 5'h00;
    {adr, tbl_phy, tbl_idx, wdat, tbl_addr} = '0;
    sel = 4'hf;
    nidx = 16'h0010;
    link_b.req_valid = 1'b0;
    link_b.req_data = 8'h00;
    link_b.req_last = 1'b0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_lookup();
    t_range();
    t_frames();
    tally_and_finish();
  end
  // roughly fifteen times the expected run
  initial begin
    #120000;
    miscompares++;
    tally_and_finish();
  end
endmodule
